// >>> fblcr_brake_dec.sv
// Braking feedback ratio decoder
`timescale 1ns/1ps

module fblcr_brake_dec (
    input  wire logic [2:0] brake_feedback_ratio,
    output logic      [4:0] ratio,
    output logic            brake_disable
);

    // ==========================================================
    // Decode
    always_comb
    begin
        brake_disable = 1'b0;
        case (brake_feedback_ratio)
            3'h0:    ratio = fblcr_pkg::BRAKE_RATIO_0;
            3'h1:    ratio = fblcr_pkg::BRAKE_RATIO_1;
            3'h2:    ratio = fblcr_pkg::BRAKE_RATIO_2; // [RL8]
            3'h3:    ratio = fblcr_pkg::BRAKE_RATIO_3; // [RL8]
            3'h4:    ratio = fblcr_pkg::BRAKE_RATIO_4; // [RL8]
            3'h5:    ratio = fblcr_pkg::BRAKE_RATIO_5; // [RL8]
            3'h6:    ratio = fblcr_pkg::BRAKE_RATIO_6; // [RL8]
            default:
            begin
                ratio         = fblcr_pkg::BRAKE_RATIO_NONE; // [RL8]
                brake_disable = 1'b1;                        // [RL8]
            end
        endcase
    end

endmodule // fblcr_brake_dec

// >>> fblcr_chk.sv
// Assertion checker for the feedback loop configuration block
`timescale 1ns/1ps

module fblcr_chk #(
    parameter int ADDR_W = 12
) (
    input wire logic              ref_clk,
    input wire logic              arst_n,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [3:0]        pstrb,
    input wire logic              cal_done,
    input wire logic [1:0]        cal_gain_code,
    input wire logic              rotating_mass_actuator_mode,
    input wire logic [1:0]        loop_speed_sel,
    input wire logic [1:0]        back_emf_amp_gain_code,
    input wire logic [11:0]       back_emf_gain_x100,
    input wire logic [2:0]        brake_feedback_ratio,
    input wire logic [4:0]        brake_ratio,
    input wire logic              brake_feedback_off
);
    // ==========================================================
    // Helpers
    localparam logic [4:0] RT [8] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h06, 5'h08, 5'h10, 5'h00};
    logic        wr;
    logic [31:0] wd_r;
    // Write data is released after the access edge, so keep a copy
    always_ff @(posedge ref_clk) wd_r <= pwdata;
    assign wr = psel && penable && pwrite && (paddr == '0) && pstrb[0];

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    sequence s_mode_code(logic m, logic [1:0] c);
        rotating_mass_actuator_mode == m ##1 back_emf_amp_gain_code == c;
    endsequence

    // ==========================================================
    // Properties
    a_speed_write:
        assert property (wr |=> loop_speed_sel == wd_r[3:2]) else $error("speed not stored");
    a_brake_write:
        assert property (wr |=> brake_feedback_ratio == wd_r[6:4]) else $error("brake not stored");
    a_ratio_map:
        assert property (wr |=> brake_ratio == RT[wd_r[6:4]]
            && brake_feedback_off == (wd_r[6:4] == 3'h7)) else $error("brake ratio wrong");
    a_gain_write:
        assert property (wr |=> back_emf_amp_gain_code == wd_r[1:0]) else $error("gain not stored");
    a_cal_load:
        assert property (cal_done && !wr |=> back_emf_amp_gain_code == $past(cal_gain_code))
            else $error("calibrated gain lost");
    a_gain_hold:
        assert property (!wr && !cal_done |=> $stable(back_emf_amp_gain_code))
            else $error("gain changed unasked");
    a_rot_top_gain:
        assert property (s_mode_code(1'b1, 2'h3) |-> back_emf_gain_x100 == 12'h0B6)
            else $error("code 3 gain wrong");
    a_rot_low_gain:
        assert property (s_mode_code(1'b1, 2'h0) |-> back_emf_gain_x100 == 12'h022)
            else $error("rotating gain wrong");
    a_res_mid_gain:
        assert property (s_mode_code(1'b0, 2'h1) |-> back_emf_gain_x100 == 12'h3E8)
            else $error("resonant gain wrong");
endmodule // fblcr_chk

bind fblcr_top fblcr_chk #(.ADDR_W(ADDR_W)) i_fblcr_chk (.ref_clk, .arst_n, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb, .cal_done, .cal_gain_code, .rotating_mass_actuator_mode,
    .loop_speed_sel, .back_emf_amp_gain_code, .back_emf_gain_x100, .brake_feedback_ratio,
    .brake_ratio, .brake_feedback_off);

// >>> fblcr_gain_dec.sv
// Back-EMF amplifier gain decoder per actuator type
`timescale 1ns/1ps

module fblcr_gain_dec (
    input  wire logic [1:0]  gain_code,
    input  wire logic        rotating_mass_actuator_mode,
    output logic      [11:0] gain_x100
);

    // ==========================================================
    // Decode
    always_comb
    begin
        case (gain_code)
            fblcr_pkg::GAIN_CODE_LOW:
                gain_x100 = rotating_mass_actuator_mode ? fblcr_pkg::ROT_GAIN_LOW
                                                        : fblcr_pkg::RES_GAIN_LOW; // [RL5]
            fblcr_pkg::GAIN_CODE_MID:
                gain_x100 = rotating_mass_actuator_mode ? fblcr_pkg::ROT_GAIN_MID
                                                        : fblcr_pkg::RES_GAIN_MID; // [RL5]
            // Undefined code 3 falls to the top gain
            default:
                gain_x100 = rotating_mass_actuator_mode ? fblcr_pkg::ROT_GAIN_HIGH
                                                        : fblcr_pkg::RES_GAIN_HIGH; // [RL5] [RL10]
        endcase
    end

endmodule // fblcr_gain_dec

// >>> fblcr_pkg.sv
// Shared constants and state type for the feedback loop configuration block
package fblcr_pkg;

    // ==========================================================
    // Register map
    localparam logic [11:0] FB_CTRL_OFFSET   = 12'h000;
    localparam logic [11:0] FB_STATUS_OFFSET = 12'h004;

    // ==========================================================
    // Control register fields
    localparam int BRAKE_MSB = 6;
    localparam int BRAKE_LSB = 4;
    localparam int SPEED_MSB = 3;
    localparam int SPEED_LSB = 2;
    localparam int GAIN_MSB  = 1;
    localparam int GAIN_LSB  = 0;

    localparam logic [2:0] BRAKE_RST = 3'h3;
    localparam logic [1:0] SPEED_RST = 2'h1;
    localparam logic [1:0] GAIN_RST  = 2'h2;

    // ==========================================================
    // Status register fields
    localparam int STAT_GAIN_CAL  = 0;
    localparam int STAT_BRAKE_OFF = 1;
    localparam int STAT_ROT_MASS  = 2;

    // ==========================================================
    // Loop speed codes
    localparam logic [1:0] SPEED_VERY_SLOW = 2'h0;
    localparam logic [1:0] SPEED_SLOW      = 2'h1;
    localparam logic [1:0] SPEED_FAST      = 2'h2;
    localparam logic [1:0] SPEED_VERY_FAST = 2'h3;

    // ==========================================================
    // Gain codes and amplifier gains in hundredths
    localparam logic [1:0]  GAIN_CODE_LOW  = 2'h0;
    localparam logic [1:0]  GAIN_CODE_MID  = 2'h1;
    localparam logic [1:0]  GAIN_CODE_HIGH = 2'h2;
    localparam logic [11:0] RES_GAIN_LOW   = 12'h1F4;
    localparam logic [11:0] RES_GAIN_MID   = 12'h3E8;
    localparam logic [11:0] RES_GAIN_HIGH  = 12'h7D0;
    localparam logic [11:0] ROT_GAIN_LOW   = 12'h022;
    localparam logic [11:0] ROT_GAIN_MID   = 12'h069;
    localparam logic [11:0] ROT_GAIN_HIGH  = 12'h0B6;

    // ==========================================================
    // Brake ratio table
    localparam logic [4:0] BRAKE_RATIO_0 = 5'h01;
    localparam logic [4:0] BRAKE_RATIO_1 = 5'h02;
    localparam logic [4:0] BRAKE_RATIO_2 = 5'h03;
    localparam logic [4:0] BRAKE_RATIO_3 = 5'h04;
    localparam logic [4:0] BRAKE_RATIO_4 = 5'h06;
    localparam logic [4:0] BRAKE_RATIO_5 = 5'h08;
    localparam logic [4:0] BRAKE_RATIO_6 = 5'h10;
    localparam logic [4:0] BRAKE_RATIO_NONE = 5'h00;
    localparam logic [2:0] BRAKE_CODE_OFF   = 3'h7;

    // ==========================================================
    // Block state
    typedef struct packed {
        logic [2:0]  brake_code;
        logic [1:0]  loop_speed;
        logic [1:0]  gain_code;
        logic        gain_from_cal;
        logic [31:0] prdata;
        logic [11:0] gain_x100;
        logic [4:0]  brake_ratio;
        logic        brake_disable;
    } fblcr_state_t;

endpackage

// >>> fblcr_top.sv
// Feedback loop configuration register with APB slave and decoded outputs
//
// Operation
// [RL1] Loop speed is a two-bit read/write field in bits 3:2 that resets to 1.
// [RL2] Loop speed codes 0..3 mean very slow, slow, fast, very fast and go to the controller.
// [RL3] Software sets the loop speed before it starts auto calibration.
// [RL4] Back-EMF gain code is a two-bit read/write field in bits 1:0 driving the amplifier.
// [RL5] Gain code 0/1/2 means 5x/10x/20x resonant or 0.34x/1.05x/1.82x rotating mass.
// [RL6] When calibration completes the calibrated gain code is written into the field.
// [RL7] A software write to the gain field replaces the calibrated code until the next update.
// [RL8] Brake codes 2..6 give ratios 3,4,6,8,16 and code 7 turns braking feedback off.
// [RL9] Brake ratio code is a three-bit read/write field in bits 6:4 that resets to 3.
// [RL10] Gain code 3 is stored as written but acts as the top documented gain.
//
// Our own choices: register access over APB and the address map.
`timescale 1ns/1ps

module fblcr_top #(
    parameter int ADDR_W = 12
) (
    input  wire logic              ref_clk,
    input  wire logic              arst_n,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Calibration engine
    input  wire logic              cal_done,
    input  wire logic [1:0]        cal_gain_code,
    // Actuator selection
    input  wire logic              rotating_mass_actuator_mode,
    // Controller and amplifier outputs
    output logic      [1:0]        loop_speed_sel,
    output logic      [1:0]        back_emf_amp_gain_code,
    output logic      [11:0]       back_emf_gain_x100,
    output logic      [2:0]        brake_feedback_ratio,
    output logic      [4:0]        brake_ratio,
    output logic                   brake_feedback_off
);

    // ==========================================================
    // State
    fblcr_pkg::fblcr_state_t st_r;
    fblcr_pkg::fblcr_state_t st_nxt;

    // ==========================================================
    // Bus decode
    logic              setup_ph;
    logic              access_ph;
    logic              hit_ctrl;
    logic              hit_stat;
    logic              mapped;
    logic              wr_ctrl;
    logic [7:0]        ctrl_view;
    logic [7:0]        stat_view;
    logic [ADDR_W-1:0] ctrl_addr;
    logic [ADDR_W-1:0] stat_addr;

    assign ctrl_addr = ADDR_W'(fblcr_pkg::FB_CTRL_OFFSET);
    assign stat_addr = ADDR_W'(fblcr_pkg::FB_STATUS_OFFSET);

    assign setup_ph  = psel && !penable;
    assign access_ph = psel && penable;

    always_comb
    begin
        hit_ctrl = 1'b0;
        hit_stat = 1'b0;
        if (paddr == ctrl_addr)
        begin
            hit_ctrl = 1'b1;
        end
        else if (paddr == stat_addr)
        begin
            hit_stat = 1'b1;
        end
    end

    assign mapped = hit_ctrl || hit_stat;

    // Zero wait states; status writes are dropped without error
    assign pready  = 1'b1;
    assign pslverr = access_ph && !mapped;

    // Only byte lane 0 holds bits
    assign wr_ctrl = access_ph && pwrite && hit_ctrl && pstrb[0];

    // ==========================================================
    // Read views
    always_comb
    begin
        ctrl_view = 8'h00;
        ctrl_view[fblcr_pkg::BRAKE_MSB:fblcr_pkg::BRAKE_LSB] = st_r.brake_code; // [RL9]
        ctrl_view[fblcr_pkg::SPEED_MSB:fblcr_pkg::SPEED_LSB] = st_r.loop_speed; // [RL1]
        ctrl_view[fblcr_pkg::GAIN_MSB:fblcr_pkg::GAIN_LSB]   = st_r.gain_code;  // [RL4]
    end

    always_comb
    begin
        stat_view = 8'h00;
        stat_view[fblcr_pkg::STAT_GAIN_CAL]  = st_r.gain_from_cal;
        stat_view[fblcr_pkg::STAT_BRAKE_OFF] = st_r.brake_disable;
        stat_view[fblcr_pkg::STAT_ROT_MASS]  = rotating_mass_actuator_mode;
    end

    // ==========================================================
    // Decoders
    logic [1:0]  gain_code_nxt;
    logic [2:0]  brake_code_nxt;
    logic [11:0] gain_dec;
    logic [4:0]  ratio_dec;
    logic        off_dec;

    fblcr_gain_dec u_gain_dec (
        .gain_code                   (gain_code_nxt),
        .rotating_mass_actuator_mode (rotating_mass_actuator_mode),
        .gain_x100                   (gain_dec)
    );

    fblcr_brake_dec u_brake_dec (
        .brake_feedback_ratio (brake_code_nxt),
        .ratio                (ratio_dec),
        .brake_disable        (off_dec)
    );

    // ==========================================================
    // Field updates
    // Code fields settle apart from the state fill, which reads the
    // decoders that read these; one process for both would loop on itself
    always_comb
    begin
        gain_code_nxt  = st_r.gain_code;
        brake_code_nxt = st_r.brake_code;
        if (cal_done)
        begin
            gain_code_nxt = cal_gain_code; // [RL6]
        end
        if (wr_ctrl)
        begin
            brake_code_nxt = pwdata[fblcr_pkg::BRAKE_MSB:fblcr_pkg::BRAKE_LSB]; // [RL9]
            gain_code_nxt  = pwdata[fblcr_pkg::GAIN_MSB:fblcr_pkg::GAIN_LSB];   // [RL7]
        end
    end

    always_comb
    begin
        st_nxt = st_r;

        // Calibration result lands first
        if (cal_done)
        begin
            st_nxt.gain_from_cal = 1'b1; // [RL6]
        end

        // A write in the same cycle is the newer intent and wins
        if (wr_ctrl)
        begin
            st_nxt.loop_speed    = pwdata[fblcr_pkg::SPEED_MSB:fblcr_pkg::SPEED_LSB]; // [RL1]
            st_nxt.gain_from_cal = 1'b0;                                              // [RL7]
        end

        // Code 3 is kept as written; only the decode saturates
        st_nxt.gain_code  = gain_code_nxt;  // [RL4] [RL10]
        st_nxt.brake_code = brake_code_nxt; // [RL9]

        // Decoded values follow the fields, re-evaluated every cycle so an
        // actuator type change is picked up without a register write
        st_nxt.gain_x100     = gain_dec;  // [RL5]
        st_nxt.brake_ratio   = ratio_dec; // [RL8]
        st_nxt.brake_disable = off_dec;   // [RL8]

        // Read data latched in setup so it comes out of a flop in access
        if (setup_ph && !pwrite)
        begin
            if (hit_ctrl)
            begin
                st_nxt.prdata = {24'h000000, ctrl_view};
            end
            else if (hit_stat)
            begin
                st_nxt.prdata = {24'h000000, stat_view};
            end
            else
            begin
                st_nxt.prdata = 32'h00000000;
            end
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_r.brake_code    <= fblcr_pkg::BRAKE_RST; // [RL9]
            st_r.loop_speed    <= fblcr_pkg::SPEED_RST; // [RL1]
            st_r.gain_code     <= fblcr_pkg::GAIN_RST;
            st_r.gain_from_cal <= 1'b0;
            st_r.prdata        <= 32'h00000000;
            st_r.gain_x100     <= fblcr_pkg::RES_GAIN_HIGH;
            st_r.brake_ratio   <= fblcr_pkg::BRAKE_RATIO_3;
            st_r.brake_disable <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // ==========================================================
    // Outputs
    assign prdata                 = st_r.prdata;
    // Calibration uses this live setting, so it must be set beforehand
    assign loop_speed_sel         = st_r.loop_speed;    // [RL2] [RL3]
    assign back_emf_amp_gain_code = st_r.gain_code;     // [RL4]
    assign back_emf_gain_x100     = st_r.gain_x100;     // [RL5]
    assign brake_feedback_ratio   = st_r.brake_code;    // [RL9]
    assign brake_ratio            = st_r.brake_ratio;   // [RL8]
    assign brake_feedback_off     = st_r.brake_disable; // [RL8]

endmodule // fblcr_top

// >>> tb_top.sv
// Self-checking testbench for the feedback loop configuration block
`timescale 1ns/1ps

module tb_top;
    logic        ref_clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic        cal_done = 0, rotating_mass_actuator_mode = 0, brake_feedback_off, er;
    logic [11:0] paddr = '0, back_emf_gain_x100;
    logic [31:0] pwdata = '0, prdata, rd, d;
    logic [3:0]  pstrb = '0;
    logic [1:0]  cal_gain_code = '0, loop_speed_sel, back_emf_amp_gain_code, g;
    logic [2:0]  brake_feedback_ratio;
    logic [4:0]  brake_ratio;
    int          miscompares = 0, n_checks = 0;
    logic [4:0]  rt [8] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h06, 5'h08, 5'h10, 5'h00};
    logic [11:0] res [4] = '{12'h1F4, 12'h3E8, 12'h7D0, 12'h7D0};
    logic [11:0] rot [4] = '{12'h022, 12'h069, 12'h0B6, 12'h0B6};

    fblcr_top i_fblcr_top (.ref_clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .cal_done, .cal_gain_code, .rotating_mass_actuator_mode,
        .loop_speed_sel, .back_emf_amp_gain_code, .back_emf_gain_x100, .brake_feedback_ratio,
        .brake_ratio, .brake_feedback_off);

    always #5 ref_clk = ~ref_clk;

    // ==========================================================
    // Tasks
    task cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_checks++;
        if (s !== e)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask

    // One APB transfer; result lands in rd and er
    task apb(input logic w, input logic [11:0] a, input logic [31:0] wd, input logic [3:0] s);
        @(posedge ref_clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= wd;
        pstrb   <= s;
        @(posedge ref_clk);
        penable <= 1'b1;
        // Waits for the slave; only the watchdog ends a hung transfer
        @(posedge ref_clk);
        while (pready !== 1'b1)
        begin
            @(posedge ref_clk);
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask

    task cal(input logic [1:0] c);
        @(posedge ref_clk);
        cal_done      <= 1'b1;
        cal_gain_code <= c;
        @(posedge ref_clk);
        cal_done      <= 1'b0;
        #1;
    endtask

    task conclude();
        if (miscompares == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ==========================================================
    // Tests
    initial
    begin
        #200000;
        miscompares++;
        conclude();
    end

    initial
    begin
        repeat (5) @(posedge ref_clk);
        arst_n <= 1'b1;
        apb(1'b0, 12'h000, '0, 4'hF);
        cmp("ctrl_reset", 32'h36, rd);
        cmp("ratio_reset", 32'h4, 32'(brake_ratio));
        for (int m = 0; m < 2; m++)
        begin
            @(posedge ref_clk);
            rotating_mass_actuator_mode <= m[0];
            for (int i = 0; i < 8; i++)
            begin
                g = i[1:0] ^ {2{m[0]}};
                d = {25'h0, i[2:0], i[1:0], g};
                apb(1'b1, 12'h000, d, 4'hF);
                cmp("speed", 32'(i[1:0]), 32'(loop_speed_sel));
                cmp("ratio", 32'(rt[i]), 32'(brake_ratio));
                cmp("brake_off", 32'(i == 7), 32'(brake_feedback_off));
                cmp("gain", 32'(g), 32'(back_emf_amp_gain_code));
                cmp("x100", 32'(m ? rot[g] : res[g]), 32'(back_emf_gain_x100));
                apb(1'b0, 12'h000, '0, 4'hF);
                cmp("ctrl_read", d, rd);
                cmp("ctrl_err", 32'h0, 32'(er));
            end
        end
        cal(2'h0);
        cmp("cal_gain", 32'h0, 32'(back_emf_amp_gain_code));
        cmp("cal_x100", 32'h022, 32'(back_emf_gain_x100));
        apb(1'b0, 12'h004, '0, 4'hF);
        cmp("status_cal", 32'h7, rd);
        apb(1'b1, 12'h000, 32'h75, 4'hF);
        cmp("host_gain", 32'h1, 32'(back_emf_amp_gain_code));
        cmp("host_x100", 32'h069, 32'(back_emf_gain_x100));
        // Write and calibration taken at one edge: the write wins
        fork
            apb(1'b1, 12'h000, 32'h75, 4'hF);
            begin
                @(posedge ref_clk);
                cal(2'h3);
            end
        join
        cmp("race_gain", 32'h1, 32'(back_emf_amp_gain_code));
        apb(1'b0, 12'h004, '0, 4'hF);
        cmp("status_host", 32'h6, rd);
        apb(1'b1, 12'h000, 32'h02, 4'h0);
        apb(1'b1, 12'h004, 32'h02, 4'hF);
        apb(1'b0, 12'h008, '0, 4'hF);
        cmp("unmapped_err", 32'h1, 32'(er));
        cmp("unmapped_data", 32'h0, rd);
        apb(1'b0, 12'h000, '0, 4'hF);
        cmp("ctrl_kept", 32'h75, rd);
        // Second reset in mid-run
        @(posedge ref_clk);
        arst_n <= 1'b0;
        repeat (5) @(posedge ref_clk);
        arst_n <= 1'b1;
        apb(1'b0, 12'h000, '0, 4'hF);
        cmp("ctrl_rereset", 32'h36, rd);
        cmp("x100_rereset", 32'h0B6, 32'(back_emf_gain_x100));
        conclude();
    end
endmodule // tb_top
